// file: verilog/irq_bank_pkg.sv
// Package with register map, field layout, reset values and pulse counts of the interrupt bank.
package irq_bank_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_DATAPATH_CTRL  = 8'h03;
  localparam logic [7:0] ADDR_PIN_A_CFG      = 8'h40;
  localparam logic [7:0] ADDR_PIN_B_CFG      = 8'h41;
  localparam logic [7:0] ADDR_VIDEO_LIVE     = 8'h43;
  localparam logic [7:0] ADDR_VIDEO_LATCHED  = 8'h44;
  localparam logic [7:0] ADDR_VIDEO_CLEAR    = 8'h45;
  localparam logic [7:0] ADDR_VIDEO_MASK_B   = 8'h46;
  localparam logic [7:0] ADDR_VIDEO_MASK_A   = 8'h47;
  localparam logic [7:0] ADDR_CEC_LIVE       = 8'h49;
  localparam logic [7:0] ADDR_CEC_LATCHED    = 8'h4a;
  localparam logic [7:0] ADDR_CEC_CLEAR      = 8'h4b;
  localparam logic [7:0] ADDR_CEC_MASK_B     = 8'h4c;
  localparam logic [7:0] ADDR_CEC_MASK_A     = 8'h4d;

  // Video group bit positions (lock, unlock, mute request, forced, standard definition).
  localparam int VID_LOCK   = 7;
  localparam int VID_UNLOCK = 6;
  localparam int VID_MUTE   = 5;
  localparam int VID_FORCED = 1;
  localparam int VID_STDDEF = 0;
  localparam logic [7:0] VID_USED_MASK = 8'he3;
  localparam logic [7:0] VID_LOCK_MASK = 8'hc0;

  // CEC group bit positions; receive buffers sit at bits 3 to 5.
  localparam int CEC_RX_BASE   = 3;
  localparam int CEC_RETRY     = 2;
  localparam int CEC_ARB_LOST  = 1;
  localparam int CEC_TX_DONE   = 0;
  localparam logic [7:0] CEC_USED_MASK = 8'h3f;

  // Control fields.
  localparam int FREE_RUN_BIT  = 1;
  localparam int DUR_SEL_LSB   = 6;
  localparam int FORCED_BIT    = 2;
  localparam int DRIVE_SEL_LSB = 0;

  // Reset values.
  localparam logic [7:0] DATAPATH_CTRL_RST = 8'h06;
  localparam logic [7:0] PIN_CFG_RST       = 8'h00;
  localparam logic [7:0] MASK_RST          = 8'h00;

  // Pulse widths in crystal periods; the core clock is the crystal clock.
  localparam logic [6:0] PULSE_SHORT = 7'h04;
  localparam logic [6:0] PULSE_MID   = 7'h10;
  localparam logic [6:0] PULSE_LONG  = 7'h40;

  // Duration and drive selector codes.
  localparam logic [1:0] DUR_LEVEL   = 2'h3;
  localparam logic [1:0] DRV_OPEN    = 2'h0;
  localparam logic [1:0] DRV_LOW     = 2'h1;
  localparam logic [1:0] DRV_HIGH    = 2'h2;
  localparam logic [1:0] DRV_OFF     = 2'h3;

  // Configuration of one interrupt pin.
  typedef struct packed {
    logic [1:0] dur_sel;
    logic [1:0] drive_sel;
  } pin_cfg_type;

  // Two signals of one interrupt pad.
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_type;

endpackage

// file: verilog/sticky_bank.sv
// Bank of sticky status bits with set-over-clear priority.
`timescale 1ns/1ns
`default_nettype none
module sticky_bank #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Set and clear strobes, one bit per flag.
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // Latched flags.
  output logic      [WIDTH-1:0] flag_q
);

  // One flop per flag; a set in the clearing cycle keeps the flag so no event is lost.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        flag_q[i] <= 1'b0;
      end else if (set[i]) begin
        flag_q[i] <= 1'b1;
      end else if (clr[i]) begin
        flag_q[i] <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/irq_pin_driver.sv
// Shapes one raw interrupt indication into a timed, configured pad drive.
`timescale 1ns/1ns
`default_nettype none
module irq_pin_driver (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Raw indication and configuration.
  input  wire logic                        raw,
  input  wire irq_bank_pkg::pin_cfg_type   cfg,
  // Pad drive.
  output irq_bank_pkg::pin_drive_type      pad_q
);

  logic       raw_prev_q;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] load_val;
  logic       rise;
  logic       pulse_on;
  logic       active;
  irq_bank_pkg::pin_drive_type pad_d;

  // Pulse length picked by the duration code; a new edge during a pulse is not restarted.
  assign load_val = (cfg.dur_sel == 2'h0) ? irq_bank_pkg::PULSE_SHORT :
                    (cfg.dur_sel == 2'h1) ? irq_bank_pkg::PULSE_MID : irq_bank_pkg::PULSE_LONG;
  assign rise     = raw & ~raw_prev_q;
  assign pulse_on = (cnt_q != 7'h00);
  assign cnt_d    = (rise && !pulse_on && cfg.dur_sel != irq_bank_pkg::DUR_LEVEL) ? load_val :
                    pulse_on ? cnt_q - 7'h01 : 7'h00;
  assign active   = (cfg.dur_sel == irq_bank_pkg::DUR_LEVEL) ? raw : pulse_on;

  // Pad mode decode: open drain pulls low only, push-pull either polarity, or off.
  assign pad_d.out = (cfg.drive_sel == irq_bank_pkg::DRV_HIGH) ? active :
                     (cfg.drive_sel == irq_bank_pkg::DRV_LOW) ? ~active : 1'b0;
  assign pad_d.oe  = (cfg.drive_sel == irq_bank_pkg::DRV_OPEN) ? active :
                     (cfg.drive_sel != irq_bank_pkg::DRV_OFF);

  // Counter, edge history and registered pad.
  always_ff @(posedge clk) begin
    if (rst) begin
      raw_prev_q <= 1'b0;
      cnt_q      <= 7'h00;
      pad_q      <= '0;
    end else begin
      raw_prev_q <= raw;
      cnt_q      <= cnt_d;
      pad_q      <= pad_d;
    end
  end

  property p_short_pulse;
    @(posedge clk) disable iff (rst)
      (rise && !pulse_on && cfg.dur_sel == 2'h0) |=> pulse_on [*4] ##1 !pulse_on;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse not four cycles");

  property p_pad_off;
    @(posedge clk) disable iff (rst)
      (cfg.drive_sel == irq_bank_pkg::DRV_OFF) |=> !pad_q.oe;
  endproperty
  a_pad_off: assert property (p_pad_off) else $error("disabled pad still driven");

  c_long_pulse: cover property (@(posedge clk) disable iff (rst) (cnt_q == irq_bank_pkg::PULSE_LONG));

endmodule
`default_nettype wire

// file: verilog/irq_status_mask_clear_bank.sv
// Top of the interrupt status, clear and mask bank with its byte register port.
//
// Notes on behaviour
// - Forced interrupt event latches a sticky bit held until its clear bit is written.
// - Any change of the standard-definition raw interrupt latches its sticky bit.
// - A latched bit only counts when a mask bit for either output is set.
// - Writing one to a video clear bit clears that latched bit; zero does nothing.
// - Lock and unlock interrupts and their masks work only while free-run is enabled.
// - Second-output mask bits enable each video source onto pin b and into status.
// - First-output mask bits enable each video source onto pin a and into status.
// - Each receive buffer raises a live ready flag once a whole frame waits.
// - A live retry-expired flag rises after all configured retries failed.
// - A live arbitration-lost flag rises when the transmitter loses arbitration.
// - A live transmit-done flag goes high when a message was sent successfully.
// - Each receive buffer latches a sticky ready bit until its clear bit is written.
// - Retry expiry latches a sticky bit until it is cleared.
// - Arbitration loss latches a sticky bit until its clear bit is written.
// - Transmit done latches a sticky bit until its clear bit is written.
// - Writing one to a CEC clear bit clears that latched bit; zero does nothing.
// - Each output's raw indication stays high until all its enabled bits clear.
// - Duration code gives 4, 16 or 64 crystal periods, or active until cleared.
// - Drive code gives open drain, active low, active high or disabled pin.
// - A manual control bit makes the forced event; it reaches pins only when masked in.
`timescale 1ns/1ns
`default_nettype none
module irq_status_mask_clear_bank (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Byte register port.
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  output logic            reg_rvalid_q,
  // Video event sources.
  input  wire logic       lock_live,
  input  wire logic       unlock_live,
  input  wire logic       mute_request_live,
  input  wire logic       stddef_irq_live,
  // CEC event sources.
  input  wire logic [2:0] rx_buf_ready_live,
  input  wire logic       tx_retry_expired_live,
  input  wire logic       tx_arb_lost_live,
  input  wire logic       tx_done_live,
  // Interrupt pads.
  output logic            irq_pin_a_out,
  output logic            irq_pin_a_oe,
  output logic            irq_pin_b_out,
  output logic            irq_pin_b_oe
);

  // Control and mask registers.
  logic [7:0] datapath_ctrl_q;
  logic [7:0] pin_a_cfg_q;
  logic [7:0] pin_b_cfg_q;
  logic [7:0] video_irq_mask_out_a_q;
  logic [7:0] video_irq_mask_out_b_q;
  logic [7:0] cec_irq_mask_out_a_q;
  logic [7:0] cec_irq_mask_out_b_q;
  logic [7:0] video_live_q;
  logic [7:0] video_prev_q;
  logic [7:0] cec_irq_raw_status_q;
  logic [7:0] cec_prev_q;
  logic       raw_a_q;
  logic       raw_b_q;

  // Decode and event wires.
  logic [7:0] video_live;
  logic [7:0] cec_live;
  logic [7:0] video_evt;
  logic [7:0] cec_evt;
  logic [7:0] video_gate;
  logic [7:0] video_en;
  logic [7:0] cec_en;
  logic [7:0] video_set;
  logic [7:0] cec_set;
  logic [7:0] video_clr;
  logic [7:0] cec_clr;
  logic [7:0] forced_and_sd_irq_status;
  logic [7:0] cec_irq_latched_status;
  logic [7:0] rd_mux;
  logic       free_run_en;
  logic       forced_irq_control;
  logic       raw_a;
  logic       raw_b;
  logic       wr_ctrl;
  logic       wr_pin_a;
  logic       wr_pin_b;
  logic       wr_vmask_a;
  logic       wr_vmask_b;
  logic       wr_cmask_a;
  logic       wr_cmask_b;
  logic       wr_vclr;
  logic       wr_cclr;
  irq_bank_pkg::pin_drive_type pad_a;
  irq_bank_pkg::pin_drive_type pad_b;

  // Write strobes per register.
  assign wr_ctrl    = reg_wr && (reg_addr == irq_bank_pkg::ADDR_DATAPATH_CTRL);
  assign wr_pin_a   = reg_wr && (reg_addr == irq_bank_pkg::ADDR_PIN_A_CFG);
  assign wr_pin_b   = reg_wr && (reg_addr == irq_bank_pkg::ADDR_PIN_B_CFG);
  assign wr_vmask_a = reg_wr && (reg_addr == irq_bank_pkg::ADDR_VIDEO_MASK_A);
  assign wr_vmask_b = reg_wr && (reg_addr == irq_bank_pkg::ADDR_VIDEO_MASK_B);
  assign wr_cmask_a = reg_wr && (reg_addr == irq_bank_pkg::ADDR_CEC_MASK_A);
  assign wr_cmask_b = reg_wr && (reg_addr == irq_bank_pkg::ADDR_CEC_MASK_B);
  assign wr_vclr    = reg_wr && (reg_addr == irq_bank_pkg::ADDR_VIDEO_CLEAR);
  assign wr_cclr    = reg_wr && (reg_addr == irq_bank_pkg::ADDR_CEC_CLEAR);

  assign free_run_en        = datapath_ctrl_q[irq_bank_pkg::FREE_RUN_BIT];
  assign forced_irq_control = pin_a_cfg_q[irq_bank_pkg::FORCED_BIT];

  // Live source vectors in register bit order.
  always_comb begin
    video_live = 8'h00;
    video_live[irq_bank_pkg::VID_LOCK]   = lock_live;
    video_live[irq_bank_pkg::VID_UNLOCK] = unlock_live;
    video_live[irq_bank_pkg::VID_MUTE]   = mute_request_live;
    video_live[irq_bank_pkg::VID_FORCED] = forced_irq_control;
    video_live[irq_bank_pkg::VID_STDDEF] = stddef_irq_live;
    cec_live = 8'h00;
    cec_live[irq_bank_pkg::CEC_RX_BASE +: 3]  = rx_buf_ready_live;
    cec_live[irq_bank_pkg::CEC_RETRY]    = tx_retry_expired_live;
    cec_live[irq_bank_pkg::CEC_ARB_LOST] = tx_arb_lost_live;
    cec_live[irq_bank_pkg::CEC_TX_DONE]  = tx_done_live;
  end

  // Rising edges set status, except standard definition which reacts to any change.
  assign video_evt = (video_live & ~video_prev_q) |
                     ((video_live ^ video_prev_q) & (8'h01 << irq_bank_pkg::VID_STDDEF));
  assign cec_evt   = cec_live & ~cec_prev_q;

  // Lock sources and their masks are dead while free-run is off.
  assign video_gate = free_run_en ? irq_bank_pkg::VID_USED_MASK :
                      (irq_bank_pkg::VID_USED_MASK & ~irq_bank_pkg::VID_LOCK_MASK);
  assign video_en   = (video_irq_mask_out_a_q | video_irq_mask_out_b_q) & video_gate;
  assign cec_en     = (cec_irq_mask_out_a_q | cec_irq_mask_out_b_q) & irq_bank_pkg::CEC_USED_MASK;
  assign video_set  = video_evt & video_en;
  assign cec_set    = cec_evt & cec_en;

  // Clear bits act only in the write cycle, so nothing needs to self-clear later.
  assign video_clr = wr_vclr ? reg_wdata : 8'h00;
  assign cec_clr   = wr_cclr ? reg_wdata : 8'h00;

  sticky_bank #(
    .WIDTH (8)
  ) u_video_bank (
    .clk    (clk),
    .rst    (rst),
    .set    (video_set),
    .clr    (video_clr),
    .flag_q (forced_and_sd_irq_status)
  );

  sticky_bank #(
    .WIDTH (8)
  ) u_cec_bank (
    .clk    (clk),
    .rst    (rst),
    .set    (cec_set),
    .clr    (cec_clr),
    .flag_q (cec_irq_latched_status)
  );

  // Output indications hold while any enabled latched bit remains.
  assign raw_a = |(forced_and_sd_irq_status & video_irq_mask_out_a_q & video_gate) |
                 |(cec_irq_latched_status & cec_irq_mask_out_a_q);
  assign raw_b = |(forced_and_sd_irq_status & video_irq_mask_out_b_q & video_gate) |
                 |(cec_irq_latched_status & cec_irq_mask_out_b_q);

  irq_pin_driver u_pin_a (
    .clk   (clk),
    .rst   (rst),
    .raw   (raw_a),
    .cfg   ({pin_a_cfg_q[irq_bank_pkg::DUR_SEL_LSB +: 2], pin_a_cfg_q[irq_bank_pkg::DRIVE_SEL_LSB +: 2]}),
    .pad_q (pad_a)
  );

  irq_pin_driver u_pin_b (
    .clk   (clk),
    .rst   (rst),
    .raw   (raw_b),
    .cfg   ({pin_b_cfg_q[irq_bank_pkg::DUR_SEL_LSB +: 2], pin_b_cfg_q[irq_bank_pkg::DRIVE_SEL_LSB +: 2]}),
    .pad_q (pad_b)
  );

  assign irq_pin_a_out = pad_a.out;
  assign irq_pin_a_oe  = pad_a.oe;
  assign irq_pin_b_out = pad_b.out;
  assign irq_pin_b_oe  = pad_b.oe;

  // Read selection; clear registers and unmapped offsets read zero.
  assign rd_mux = (reg_addr == irq_bank_pkg::ADDR_DATAPATH_CTRL) ? datapath_ctrl_q :
                  (reg_addr == irq_bank_pkg::ADDR_PIN_A_CFG)     ? pin_a_cfg_q :
                  (reg_addr == irq_bank_pkg::ADDR_PIN_B_CFG)     ? pin_b_cfg_q :
                  (reg_addr == irq_bank_pkg::ADDR_VIDEO_LIVE)    ? video_live_q :
                  (reg_addr == irq_bank_pkg::ADDR_VIDEO_LATCHED) ? forced_and_sd_irq_status :
                  (reg_addr == irq_bank_pkg::ADDR_VIDEO_MASK_B)  ? video_irq_mask_out_b_q :
                  (reg_addr == irq_bank_pkg::ADDR_VIDEO_MASK_A)  ? video_irq_mask_out_a_q :
                  (reg_addr == irq_bank_pkg::ADDR_CEC_LIVE)      ? cec_irq_raw_status_q :
                  (reg_addr == irq_bank_pkg::ADDR_CEC_LATCHED)   ? cec_irq_latched_status :
                  (reg_addr == irq_bank_pkg::ADDR_CEC_MASK_B)    ? cec_irq_mask_out_b_q :
                  (reg_addr == irq_bank_pkg::ADDR_CEC_MASK_A)    ? cec_irq_mask_out_a_q : 8'h00;

  // Control and mask registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      datapath_ctrl_q        <= irq_bank_pkg::DATAPATH_CTRL_RST;
      pin_a_cfg_q            <= irq_bank_pkg::PIN_CFG_RST;
      pin_b_cfg_q            <= irq_bank_pkg::PIN_CFG_RST;
      video_irq_mask_out_a_q <= irq_bank_pkg::MASK_RST;
      video_irq_mask_out_b_q <= irq_bank_pkg::MASK_RST;
      cec_irq_mask_out_a_q   <= irq_bank_pkg::MASK_RST;
      cec_irq_mask_out_b_q   <= irq_bank_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) datapath_ctrl_q <= reg_wdata;
      if (wr_pin_a) pin_a_cfg_q <= reg_wdata;
      if (wr_pin_b) pin_b_cfg_q <= reg_wdata;
      if (wr_vmask_a) video_irq_mask_out_a_q <= reg_wdata & irq_bank_pkg::VID_USED_MASK;
      if (wr_vmask_b) video_irq_mask_out_b_q <= reg_wdata & irq_bank_pkg::VID_USED_MASK;
      if (wr_cmask_a) cec_irq_mask_out_a_q <= reg_wdata & irq_bank_pkg::CEC_USED_MASK;
      if (wr_cmask_b) cec_irq_mask_out_b_q <= reg_wdata & irq_bank_pkg::CEC_USED_MASK;
    end
  end

  // Edge history, live snapshots and the registered read answer.
  always_ff @(posedge clk) begin
    if (rst) begin
      video_prev_q         <= 8'h00;
      cec_prev_q           <= 8'h00;
      video_live_q         <= 8'h00;
      cec_irq_raw_status_q <= 8'h00;
      reg_rdata_q          <= 8'h00;
      reg_rvalid_q         <= 1'b0;
      raw_a_q              <= 1'b0;
      raw_b_q              <= 1'b0;
    end else begin
      video_prev_q         <= video_live;
      cec_prev_q           <= cec_live;
      video_live_q         <= video_live;
      cec_irq_raw_status_q <= cec_live;
      reg_rdata_q          <= reg_rd ? rd_mux : 8'h00;
      reg_rvalid_q         <= reg_rd;
      raw_a_q              <= raw_a;
      raw_b_q              <= raw_b;
    end
  end

  // Checks kept beside the logic.
  property p_forced_sticky;
    @(posedge clk) disable iff (rst)
      (forced_and_sd_irq_status[irq_bank_pkg::VID_FORCED] && !video_clr[irq_bank_pkg::VID_FORCED])
        |=> forced_and_sd_irq_status[irq_bank_pkg::VID_FORCED];
  endproperty
  a_forced_sticky: assert property (p_forced_sticky) else $error("forced status dropped");

  property p_stddef_change;
    @(posedge clk) disable iff (rst)
      ($changed(stddef_irq_live) && video_en[irq_bank_pkg::VID_STDDEF])
        |=> forced_and_sd_irq_status[irq_bank_pkg::VID_STDDEF];
  endproperty
  a_stddef_change: assert property (p_stddef_change) else $error("stddef change not latched");

  property p_video_clear;
    @(posedge clk) disable iff (rst)
      (wr_vclr && reg_wdata[irq_bank_pkg::VID_MUTE] && !video_set[irq_bank_pkg::VID_MUTE])
        |=> !forced_and_sd_irq_status[irq_bank_pkg::VID_MUTE];
  endproperty
  a_video_clear: assert property (p_video_clear) else $error("mute status not cleared");

  property p_lock_gate;
    @(posedge clk) disable iff (rst)
      !free_run_en |=> !$rose(forced_and_sd_irq_status[irq_bank_pkg::VID_LOCK]);
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("lock latched without free-run");

  property p_unmasked_no_record;
    @(posedge clk) disable iff (rst)
      (!video_irq_mask_out_a_q[irq_bank_pkg::VID_MUTE] && !video_irq_mask_out_b_q[irq_bank_pkg::VID_MUTE])
        |=> !$rose(forced_and_sd_irq_status[irq_bank_pkg::VID_MUTE]);
  endproperty
  a_unmasked_no_record: assert property (p_unmasked_no_record) else $error("masked source recorded");

  property p_mask_b_record;
    @(posedge clk) disable iff (rst)
      ($rose(mute_request_live) && video_irq_mask_out_b_q[irq_bank_pkg::VID_MUTE])
        |=> forced_and_sd_irq_status[irq_bank_pkg::VID_MUTE] ##1 raw_b_q;
  endproperty
  a_mask_b_record: assert property (p_mask_b_record) else $error("pin b source not recorded");

  property p_mask_a_route;
    @(posedge clk) disable iff (rst)
      ($rose(tx_done_live) && cec_irq_mask_out_a_q[irq_bank_pkg::CEC_TX_DONE]) |=> ##1 raw_a_q;
  endproperty
  a_mask_a_route: assert property (p_mask_a_route) else $error("pin a not raised");

  property p_rx_latch;
    @(posedge clk) disable iff (rst)
      ($rose(rx_buf_ready_live[0]) && cec_en[irq_bank_pkg::CEC_RX_BASE])
        |=> cec_irq_latched_status[irq_bank_pkg::CEC_RX_BASE];
  endproperty
  a_rx_latch: assert property (p_rx_latch) else $error("rx ready not latched");

  property p_raw_hold;
    @(posedge clk) disable iff (rst)
      $fell(raw_a_q) |-> $past(wr_vclr || wr_cclr || wr_vmask_a || wr_cmask_a || wr_ctrl, 2);
  endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("pin a raw fell without clear");

  property p_set_wins;
    @(posedge clk) disable iff (rst)
      (cec_set[irq_bank_pkg::CEC_ARB_LOST] && cec_clr[irq_bank_pkg::CEC_ARB_LOST])
        |=> cec_irq_latched_status[irq_bank_pkg::CEC_ARB_LOST];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_clear_reads_zero;
    @(posedge clk) disable iff (rst)
      (reg_rd && (reg_addr == irq_bank_pkg::ADDR_CEC_CLEAR)) |=> reg_rvalid_q && (reg_rdata_q == 8'h00);
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read nonzero");

  c_forced: cover property (@(posedge clk) disable iff (rst) $rose(forced_and_sd_irq_status[irq_bank_pkg::VID_FORCED]));
  c_pin_a: cover property (@(posedge clk) disable iff (rst) $rose(irq_pin_a_oe));
  c_collide: cover property (@(posedge clk) disable iff (rst) |(cec_set & cec_clr));

endmodule
`default_nettype wire

// file: testbench/event_source_model.sv
// Behavioural model of the raw event sources that feed the interrupt bank.
`timescale 1ns/1ns
`default_nettype none
module event_source_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // One toggle request per source line.
  input  wire logic [9:0] flip,
  // Live source levels: lock, unlock, mute, stddef, rx2..rx0, retry, arb, done.
  output logic      [9:0] live_q
);
  // Each request changes its line once, so every event is a clean level change.
  always_ff @(posedge clk) begin
    if (rst) begin
      live_q <= 10'h000;
    end else begin
      live_q <= live_q ^ flip;
    end
  end
endmodule
`default_nettype wire

// file: testbench/irq_status_mask_clear_bank_tb_top.sv
// Self-checking bench for the interrupt status, mask and clear bank.
`timescale 1ns/1ns
`default_nettype none
module irq_status_mask_clear_bank_tb_top;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, c;
  logic       rvalid, a_out, a_oe, b_out, b_oe;
  logic [9:0] flip = 10'h000, live;
  int         mismatches = 0, n_tests = 0, cycles = 0, oe_cnt = 0;
  int         widths [3] = '{4, 16, 64};

  // Free clock; the cycle ceiling cuts a hang short.
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (a_oe) oe_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  event_source_model event_source_model_inst (.clk(clk), .rst(rst), .flip(flip), .live_q(live));
  irq_status_mask_clear_bank irq_status_mask_clear_bank_inst (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .lock_live(live[9]),
    .unlock_live(live[8]), .mute_request_live(live[7]), .stddef_irq_live(live[6]), .rx_buf_ready_live(live[5:3]),
    .tx_retry_expired_live(live[2]), .tx_arb_lost_live(live[1]), .tx_done_live(live[0]), .irq_pin_a_out(a_out),
    .irq_pin_a_oe(a_oe), .irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe));

  // Shared bus cycles and comparison; inputs move 1 ns after the edge.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected pad pair {oe, out} for a drive code and an active level, from the drive rule.
  function automatic logic [7:0] exp_pad(input int drv, input logic act);
    exp_pad = (drv == 3) ? 8'h00 : (drv == 0) ? {6'h00, act, 1'b0} : {6'h00, 1'b1, (drv == 2) ? act : ~act};
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  // A missing valid pulse shows as unknown data and so always mismatches.
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input string what);
    rd = 1'b1;
    addr = a;
    step(1);
    rd = 1'b0;
    check(what, rvalid ? rdata : 8'hxx, exp);
    step(1);
  endtask
  // Toggle the chosen sources twice, leaving time for the pad to follow.
  task automatic fire(input logic [9:0] f);
    flip = f;
    step(1);
    flip = 10'h000;
    step(1);
    flip = f;
    step(1);
    flip = 10'h000;
    step(3);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'h215dbb3e));
    step(8);
    rst = 1'b0;
    rreg(8'h03, 8'h06, "datapath");
    rreg(8'h47, 8'h00, "mask a");
    rreg(8'h49, 8'h00, "cec live");
    rreg(8'h45, 8'h00, "video clear");
    rreg(8'h4b, 8'h00, "cec clear");
    rreg(8'h60, 8'h00, "unmapped");
    $display("end reset");
    wreg(8'h4d, 8'h3f);
    wreg(8'h40, 8'hc2);
    for (int i = 0; i < 6; i++) begin
      v = (8'($urandom) & 8'h3f) | 8'h01;
      c = 8'($urandom) & v;
      fire({4'h0, v[5:0]});
      rreg(8'h4a, v, "cec latched");
      check("pin a on", {6'h00, a_oe, a_out}, 8'h03);
      wreg(8'h4b, c);
      rreg(8'h4a, v & ~c, "cec cleared");
      wreg(8'h4b, 8'hff);
      step(3);
      check("pin a off", {6'h00, a_oe, a_out}, 8'h02);
    end
    wreg(8'h4d, 8'h00);
    fire(10'h03f);
    rreg(8'h4a, 8'h00, "unmasked");
    $display("end cec");
    wreg(8'h47, 8'h02);
    wreg(8'h40, 8'hc6);
    step(2);
    rreg(8'h44, 8'h02, "forced");
    wreg(8'h45, 8'h02);
    rreg(8'h44, 8'h00, "forced cleared");
    wreg(8'h40, 8'hc2);
    wreg(8'h46, 8'h01);
    wreg(8'h41, 8'hc1);
    flip = 10'h040;
    step(1);
    flip = 10'h000;
    step(3);
    rreg(8'h44, 8'h01, "stddef rise");
    check("pin b", {6'h00, b_oe, b_out}, 8'h02);
    wreg(8'h45, 8'h01);
    fire(10'h040);
    rreg(8'h44, 8'h01, "stddef fall");
    wreg(8'h45, 8'hff);
    wreg(8'h03, 8'h04);
    wreg(8'h47, 8'hc0);
    fire(10'h300);
    rreg(8'h44, 8'h00, "free run off");
    wreg(8'h03, 8'h06);
    fire(10'h300);
    rreg(8'h44, 8'hc0, "free run on");
    wreg(8'h45, 8'hff);
    wreg(8'h46, 8'h20);
    fire(10'h080);
    rreg(8'h44, 8'h20, "mute b");
    check("pin b mute", {6'h00, b_oe, b_out}, exp_pad(1, 1'b1));
    wreg(8'h45, 8'h20);
    rreg(8'h44, 8'h00, "mute cleared");
    check("pin b idle", {6'h00, b_oe, b_out}, exp_pad(1, 1'b0));
    $display("end video");
    wreg(8'h4d, 8'h01);
    flip = 10'h001;
    step(1);
    flip = 10'h000;
    wreg(8'h4b, 8'h01);
    rreg(8'h4a, 8'h01, "set over clear");
    fire(10'h001);
    for (int d = 0; d < 4; d++) begin
      wreg(8'h40, 8'hc0 | 8'(d));
      step(2);
      check("drive", {6'h00, a_oe, a_out}, exp_pad(d, 1'b1));
    end
    for (int k = 0; k < 3; k++) begin
      wreg(8'h4b, 8'h01);
      wreg(8'h40, 8'(k << 6));
      step(3);
      oe_cnt = 0;
      fire(10'h001);
      step(70);
      check("pulse", 8'(oe_cnt), 8'(widths[k]));
    end
    $display("end pin");
    complete_run();
  end
endmodule
`default_nettype wire
